//--- shared/cdi_consts.svh
// Constants of the clock divider and interrupt pin block.
`ifndef CDI_CONSTS_SVH
`define CDI_CONSTS_SVH
`define CDI_CLK_NS 20
`define CDI_DRDY_PULSE_NS 100
`define CDI_DRDY_PULSE_CYC ((`CDI_DRDY_PULSE_NS + `CDI_CLK_NS - 1) / `CDI_CLK_NS)
`define CDI_PULSE_W 4
`define CDI_OSR_W 17
`define CDI_OSR_MAX 98304
`define CDI_OSR_RST 17'h00100
`define CDI_DIGITAL_SAMPLE_CLOCK_LAST 2'h3
`define CDI_PRE_W 4
`define CDI_ADR_CLKCFG 6'h00
`define CDI_ADR_IRQCFG 6'h01
`define CDI_ADR_OSR 6'h02
`define CDI_ADR_STATE 6'h03
`define CDI_ADR_INTSTAT 6'h04
`define CDI_ADR_INTMASK 6'h05
`define CDI_SRC_EXT 2'h0
`define CDI_SRC_INT 2'h2
`define CDI_SRC_INT_OUT 2'h3
`define CDI_SRC_RST 2'h2
`define CDI_PRE_RST 2'h0
`define CDI_IRQCFG_RST 2'h0
`define CDI_IRQCFG_MODULATOR_BITSTREAM_OUT 1
`define CDI_IRQCFG_IDLE_HI 0
`define CDI_CLK_SRC_LSB 0
`define CDI_CLK_PRE_LSB 2
`define CDI_CLK_CONV_BIT 4
`define CDI_ST_PAD_BIT 4
`define CDI_ST_ASSERT_BIT 5
`define CDI_INT_DRDY 0
`define CDI_INT_PADLOW 1
`define CDI_IDLE_FULL 2'h3
`endif

//--- shared/cdi_pkg.sv
// Types of the clock divider and interrupt pin block.
`include "cdi_consts.svh"
package cdi_pkg;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] src_cfg;
      logic [1:0] pre_cfg;
      logic conv_en;
      logic [1:0] irq_cfg;
      logic [`CDI_OSR_W-1:0] osr_cfg;
      logic [1:0] src_act;
      logic [1:0] pre_act;
      logic [`CDI_OSR_W-1:0] osr_act;
      logic osc;
      logic mclk_prev;
      logic [`CDI_PRE_W-1:0] pre_cnt;
      logic analog_master_clock;
      logic [1:0] dm_cnt;
      logic [`CDI_OSR_W-1:0] osr_cnt;
      logic modulator_bitstream_out;
      logic samp;
      logic drdy;
      logic [`CDI_PULSE_W-1:0] pulse_cnt;
      logic [1:0] idle_cnt;
      logic pad_low;
      logic irq_o;
      logic irq_oe;
      logic mclk_oe;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic int_o;
   } cdi_state_t;
endpackage : cdi_pkg

//--- rtl/cdi_clk_irq.sv
// Clock divider chain, modulator bitstream and shared interrupt pin with a Wishbone register slave.
// How it works
// [RULE_01] Pin-function bit clear: shared pin shows all four interrupt sources, active low.
// [RULE_02] In interrupt mode bit zero picks idle level: released or driven high.
// [RULE_03] Pin-function bit set: pin carries modulator bitstream, refreshed on each sample strobe.
// [RULE_04] In bitstream mode a power-on or CRC interrupt forces the pin low.
// [RULE_05] Pad level is sensed; a low pad while idle is flagged and blocks data-ready.
// [RULE_06] Clock source select makes master clock pin an input or analog clock output.
// [RULE_07] Analog clock is the selected master clock divided by the prescale factor.
// [RULE_08] Sample clock is analog clock over four; one modulator bit per sample.
// [RULE_09] In continuous conversion a result comes every oversampling-ratio samples.
// [RULE_10] Each new result gives a data-ready low pulse on the interrupt pin.
// [RULE_11] Serial clock logic stays outside; master clock is only sampled here.
// [RULE_12] Prescale codes 0 to 3 divide by 1, 2, 4 and 8.
// [RULE_13] New clock settings take effect only on a sample period boundary.
`timescale 1ns/100ps
`include "cdi_consts.svh"
module cdi_clk_irq #(
   parameter int unsigned OSR_RESET = 256
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic INT_O,
   input wire logic MCLK_I,
   output logic MCLK_O,
   output logic MCLK_OE,
   input wire logic IRQ_I,
   output logic IRQ_O,
   output logic IRQ_OE,
   input wire logic MOD_BIT_I,
   input wire logic POR_PEND_I,
   input wire logic CRC_PEND_I,
   input wire logic EOS_PEND_I,
   output logic SAMPLE_O,
   output logic DRDY_O
);
   import cdi_pkg::*;

   // The divide-by-eight prescale needs a counter one bit wider than its top code.
   if (OSR_RESET < 1 || OSR_RESET > `CDI_OSR_MAX) begin : g_bad_osr
      $error("OSR_RESET out of range");
   end

   cdi_state_t st_q;
   cdi_state_t st_d;

   logic mlev;
   logic mrise;
   logic [`CDI_PRE_W-1:0] pdiv;
   logic [`CDI_PRE_W-1:0] pcnt_n;
   logic analog_master_clock_rise;
   logic samp_n;
   logic drdy_n;
   logic assert_n;
   logic lock_n;
   logic pad_fault;
   logic req;
   logic [31:0] cur;
   logic [31:0] bmask;
   logic [31:0] wval;
   logic [1:0] ev;

   always_comb begin
      st_d = st_q;
      // The master clock is only sampled as a level; it never clocks a flop. [RULE_11]
      st_d.osc = ~st_q.osc;
      mlev = st_q.src_act[1] ? st_q.osc : MCLK_I;
      st_d.mclk_prev = mlev;
      mrise = mlev & ~st_q.mclk_prev;
      pdiv = `CDI_PRE_W'(1) << st_q.pre_act; // [RULE_12]
      pcnt_n = st_q.pre_cnt;
      analog_master_clock_rise = 1'b0;
      if (mrise) begin
         if (st_q.pre_cnt == pdiv - `CDI_PRE_W'(1)) begin
            pcnt_n = '0;
            analog_master_clock_rise = 1'b1; // [RULE_07]
         end else begin
            pcnt_n = st_q.pre_cnt + `CDI_PRE_W'(1);
         end
      end
      st_d.pre_cnt = pcnt_n;
      st_d.analog_master_clock = (pdiv == `CDI_PRE_W'(1)) ? mlev : (pcnt_n < (pdiv >> 1)); // [RULE_07]
      // Driving the pin only in the output code avoids contention with an external clock source.
      st_d.mclk_oe = (st_q.src_act == `CDI_SRC_INT_OUT); // [RULE_06]
      samp_n = 1'b0;
      if (analog_master_clock_rise) begin
         st_d.dm_cnt = st_q.dm_cnt + 2'h1;
         samp_n = (st_q.dm_cnt == `CDI_DIGITAL_SAMPLE_CLOCK_LAST); // [RULE_08]
      end
      st_d.samp = samp_n;
      if (samp_n) begin
         st_d.modulator_bitstream_out = MOD_BIT_I; // [RULE_08] [RULE_03]
         // Switching only here keeps every sample and data-rate period whole. [RULE_13]
         st_d.src_act = st_q.src_cfg;
         st_d.pre_act = st_q.pre_cfg;
         st_d.pre_cnt = '0;
      end
      drdy_n = 1'b0;
      if (!st_q.conv_en) begin
         st_d.osr_cnt = '0;
         st_d.osr_act = st_q.osr_cfg;
      end else if (samp_n) begin
         if (st_q.osr_cnt >= st_q.osr_act - `CDI_OSR_W'(1)) begin
            st_d.osr_cnt = '0;
            st_d.osr_act = st_q.osr_cfg;
            drdy_n = 1'b1; // [RULE_09]
         end else begin
            st_d.osr_cnt = st_q.osr_cnt + `CDI_OSR_W'(1);
         end
      end
      st_d.drdy = drdy_n;
      // The pad must read high while idle; a stuck-low pad would hide every data-ready. [RULE_05]
      if (st_q.irq_oe && !st_q.irq_o) begin
         st_d.idle_cnt = 2'h0;
      end else if (st_q.idle_cnt != `CDI_IDLE_FULL) begin
         st_d.idle_cnt = st_q.idle_cnt + 2'h1;
      end
      // A pin that the block itself pulls low is no fault, so only a released or high pin is judged.
      st_d.pad_low = (st_q.idle_cnt == `CDI_IDLE_FULL) && (st_q.irq_o || !st_q.irq_oe) && !IRQ_I; // [RULE_05]
      pad_fault = st_d.pad_low && !st_q.pad_low;
      if (st_q.pulse_cnt != '0) begin
         st_d.pulse_cnt = st_q.pulse_cnt - `CDI_PULSE_W'(1);
      end
      if (drdy_n && !st_q.pad_low && !st_q.irq_cfg[`CDI_IRQCFG_MODULATOR_BITSTREAM_OUT]) begin
         st_d.pulse_cnt = `CDI_PULSE_W'(`CDI_DRDY_PULSE_CYC); // [RULE_10]
      end
      lock_n = POR_PEND_I | CRC_PEND_I;
      assert_n = lock_n | EOS_PEND_I | (st_d.pulse_cnt != '0); // [RULE_01]
      if (st_q.irq_cfg[`CDI_IRQCFG_MODULATOR_BITSTREAM_OUT]) begin
         st_d.irq_oe = 1'b1;
         st_d.irq_o = lock_n ? 1'b0 : st_d.modulator_bitstream_out; // [RULE_03] [RULE_04]
      end else if (assert_n) begin
         st_d.irq_oe = 1'b1;
         st_d.irq_o = 1'b0; // [RULE_01]
      end else begin
         st_d.irq_oe = st_q.irq_cfg[`CDI_IRQCFG_IDLE_HI]; // [RULE_02]
         st_d.irq_o = 1'b1;
      end
      req = WB_CYC_I & WB_STB_I & ~st_q.ack;
      st_d.ack = req;
      case (WB_ADR_I[7:2])
         `CDI_ADR_CLKCFG: cur = {27'h0, st_q.conv_en, st_q.pre_cfg, st_q.src_cfg};
         `CDI_ADR_IRQCFG: cur = {30'h0, st_q.irq_cfg};
         `CDI_ADR_OSR: cur = {15'h0, st_q.osr_cfg};
         `CDI_ADR_STATE: cur = {26'h0, ~st_q.irq_o & st_q.irq_oe, IRQ_I, st_q.pre_act, st_q.src_act};
         `CDI_ADR_INTSTAT: cur = {30'h0, st_q.int_stat};
         `CDI_ADR_INTMASK: cur = {30'h0, st_q.int_mask};
         default: cur = 32'h0;
      endcase
      bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
      wval = (cur & ~bmask) | (WB_DAT_I & bmask);
      st_d.rdata = req ? (WB_WE_I ? 32'h0 : cur) : st_q.rdata;
      ev = 2'h0;
      ev[`CDI_INT_DRDY] = drdy_n;
      ev[`CDI_INT_PADLOW] = pad_fault;
      st_d.int_stat = st_q.int_stat | ev;
      if (req && WB_WE_I) begin
         case (WB_ADR_I[7:2])
            `CDI_ADR_CLKCFG: begin
               st_d.src_cfg = wval[`CDI_CLK_SRC_LSB +: 2];
               st_d.pre_cfg = wval[`CDI_CLK_PRE_LSB +: 2];
               st_d.conv_en = wval[`CDI_CLK_CONV_BIT];
            end
            `CDI_ADR_IRQCFG: st_d.irq_cfg = wval[1:0];
            `CDI_ADR_OSR: begin
               if (wval[`CDI_OSR_W-1:0] != '0 && wval[`CDI_OSR_W-1:0] <= `CDI_OSR_W'(`CDI_OSR_MAX)) begin
                  st_d.osr_cfg = wval[`CDI_OSR_W-1:0];
               end
            end
            `CDI_ADR_INTMASK: st_d.int_mask = wval[1:0];
            default: begin
            end
         endcase
      end else if (req && WB_ADR_I[7:2] == `CDI_ADR_INTSTAT) begin
         // A read clears only what it returned; an event in the same cycle survives.
         st_d.int_stat = ev;
      end
      st_d.int_o = |(st_d.int_stat & st_d.int_mask);
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= '0;
         st_q.src_cfg <= `CDI_SRC_RST;
         st_q.src_act <= `CDI_SRC_RST;
         st_q.pre_cfg <= `CDI_PRE_RST;
         st_q.pre_act <= `CDI_PRE_RST;
         st_q.irq_cfg <= `CDI_IRQCFG_RST;
         st_q.osr_cfg <= `CDI_OSR_W'(OSR_RESET);
         st_q.osr_act <= `CDI_OSR_W'(OSR_RESET);
         st_q.irq_o <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign WB_DAT_O = st_q.rdata;
   assign WB_ACK_O = st_q.ack;
   assign INT_O = st_q.int_o;
   assign MCLK_O = st_q.analog_master_clock;
   assign MCLK_OE = st_q.mclk_oe;
   assign IRQ_O = st_q.irq_o;
   assign IRQ_OE = st_q.irq_oe;
   assign SAMPLE_O = st_q.samp;
   assign DRDY_O = st_q.drdy;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   a_irq_sources_low: assert property ( // [RULE_01]
      !st_q.irq_cfg[1] && EOS_PEND_I
      |=> IRQ_OE && !IRQ_O)
      else $error("pending interrupt did not pull the pin low");

   a_lock_sources_low: assert property ( // [RULE_01]
      !st_q.irq_cfg[1] && (POR_PEND_I || CRC_PEND_I)
      |=> IRQ_OE && !IRQ_O)
      else $error("power-on or CRC interrupt did not pull the pin low");

   a_idle_released: assert property ( // [RULE_02]
      st_q.irq_cfg == 2'h0 && !POR_PEND_I && !CRC_PEND_I && !EOS_PEND_I && st_d.pulse_cnt == '0
      |=> !IRQ_OE)
      else $error("idle pin not released in high impedance mode");

   a_modulator_bitstream_out_follows_bit: assert property ( // [RULE_03]
      st_q.irq_cfg[1] && !POR_PEND_I && !CRC_PEND_I
      |=> IRQ_OE && IRQ_O == $past(st_d.modulator_bitstream_out))
      else $error("pin does not carry the modulator bit");

   a_modulator_bitstream_out_driven: assert property ( // [RULE_03]
      st_q.irq_cfg[1]
      |=> IRQ_OE)
      else $error("pin not driven in bitstream mode");

   a_modulator_bitstream_out_steady: assert property ( // [RULE_03]
      !SAMPLE_O
      |-> $stable(st_q.modulator_bitstream_out))
      else $error("modulator bit changed between samples");

   a_modulator_bitstream_out_no_pulse: assert property ( // [RULE_03]
      DRDY_O && $past(st_q.irq_cfg[1])
      |-> st_q.pulse_cnt == '0)
      else $error("data ready pulse started in bitstream mode");

   a_lock_holds_low: assert property ( // [RULE_04]
      st_q.irq_cfg[1] && (POR_PEND_I || CRC_PEND_I)
      |=> IRQ_OE && !IRQ_O)
      else $error("power-on or CRC interrupt did not lock the pin low");

   a_pad_fault_flag: assert property ( // [RULE_05]
      st_q.idle_cnt == 2'h3 && (st_q.irq_o || !st_q.irq_oe) && !IRQ_I && !st_q.pad_low
      |=> st_q.int_stat[1])
      else $error("low pad while idle was not flagged");

   a_pad_low_blocks: assert property ( // [RULE_05]
      DRDY_O && $past(st_q.pad_low)
      |-> st_q.pulse_cnt == '0)
      else $error("data ready pulse started on a stuck pad");

   a_mclk_direction: assert property ( // [RULE_06]
      st_q.src_act == 2'h3 && $stable(st_q.src_act)
      |=> MCLK_OE || $changed(st_q.src_act))
      else $error("master clock pin not driven in output mode");

   a_mclk_oe_output: assert property ( // [RULE_06]
      st_q.src_act == `CDI_SRC_INT_OUT
      |=> MCLK_OE)
      else $error("analog clock not put out on the master clock pin");

   a_mclk_oe_input: assert property ( // [RULE_06]
      st_q.src_act != `CDI_SRC_INT_OUT
      |=> !MCLK_OE)
      else $error("master clock pin driven while it is an input");

   a_sample_div_four: assert property ( // [RULE_08]
      st_q.samp
      |-> st_q.dm_cnt == 2'h0 && $past(st_q.dm_cnt) == 2'h3)
      else $error("sample strobe not on the fourth analog clock");

   a_sample_single: assert property ( // [RULE_08]
      SAMPLE_O
      |=> !SAMPLE_O)
      else $error("sample strobe longer than one cycle");

   a_modulator_bitstream_out_capture: assert property ( // [RULE_08]
      SAMPLE_O
      |-> st_q.modulator_bitstream_out == $past(MOD_BIT_I))
      else $error("modulator bit not taken at the sample strobe");

   a_drdy_osr_wrap: assert property ( // [RULE_09]
      st_q.drdy
      |-> st_q.osr_cnt == '0 && st_q.samp && st_q.conv_en)
      else $error("data ready off the oversampling boundary");

   a_drdy_on_sample: assert property ( // [RULE_09]
      DRDY_O
      |-> SAMPLE_O)
      else $error("data ready outside a sample strobe");

   a_osr_zero_kept: assert property ( // [RULE_09]
      WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I[7:2] == `CDI_ADR_OSR && WB_DAT_I == 32'h0
      |=> $stable(st_q.osr_cfg))
      else $error("zero oversampling ratio was accepted");

   a_drdy_pulse_len: assert property ( // [RULE_10]
      st_q.drdy && st_q.pulse_cnt != '0 && !st_q.irq_cfg[1]
      |-> (IRQ_OE && !IRQ_O)[*5])
      else $error("data ready pulse shorter than required");

   a_drdy_sets_stat: assert property ( // [RULE_10]
      DRDY_O
      |-> st_q.int_stat[0])
      else $error("data ready did not set its status bit");

   a_prescale_count: assert property ( // [RULE_12]
      1'b1
      |-> st_q.pre_cnt < pdiv)
      else $error("prescale counter beyond its division ratio");

   a_switch_boundary: assert property ( // [RULE_13]
      $changed(st_q.pre_act) || $changed(st_q.src_act)
      |-> st_q.samp && st_q.pre_cnt == '0)
      else $error("clock settings changed inside a sample period");

   a_ack_one_cycle: assert property (
      WB_ACK_O
      |=> !WB_ACK_O)
      else $error("bus acknowledge longer than one cycle");

   a_ack_answers: assert property (
      WB_CYC_I && WB_STB_I && !WB_ACK_O
      |=> WB_ACK_O)
      else $error("bus request not acknowledged in the next cycle");

   a_int_from_mask: assert property (
      INT_O
      |-> |(st_q.int_stat & st_q.int_mask))
      else $error("interrupt output high with no unmasked status bit");

   c_drdy_seen: cover property (st_q.drdy && IRQ_OE);
   c_modulator_bitstream_out_mode: cover property (st_q.irq_cfg[1] && IRQ_O);
   c_mclk_out: cover property (MCLK_OE && $rose(MCLK_O));
   c_pad_fault: cover property (st_q.int_stat[1] && INT_O);
   c_ext_sample: cover property (!st_q.src_act[1] && SAMPLE_O);
endmodule : cdi_clk_irq

//--- test/cdi_host_model.sv
// Host side of the shared interrupt pin: pull-up, pad level and a stuck-low fault.
`timescale 1ns/100ps
module cdi_host_model (
   input wire logic drive_val,
   input wire logic drive_en,
   input wire logic hold_low,
   output logic pad_level
);
   // A released pin reads high through the pull-up, so the device must see high when idle.
   assign pad_level = hold_low ? 1'b0 : (drive_en ? drive_val : 1'b1);
endmodule : cdi_host_model

//--- test/cdi_clk_irq_bench.sv
// Self-checking bench for the clock divider and interrupt pin block.
`timescale 1ns/100ps
`include "cdi_consts.svh"
`define CDI_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module cdi_clk_irq_bench;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, mclk = 1'b0, hold = 1'b0;
   logic mod_bit = 1'b0, por = 1'b0, crc = 1'b0, eos = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000, q, rdat;
   logic ack, int_o, mclk_o, mclk_oe, pad, irq_o, irq_oe, samp, drdy;
   int fail_count = 0, checks_done = 0, cycles = 0, mdiv = 0, g;
   always #10 clk = ~clk;
   // External master clock of six cycles, slow enough to be sampled as a level.
   always @(posedge clk) begin
      mdiv <= (mdiv == 2) ? 0 : mdiv + 1;
      if (mdiv == 2) mclk <= ~mclk;
   end
   cdi_clk_irq #(.OSR_RESET(4)) dut (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .INT_O(int_o),
      .MCLK_I(mclk), .MCLK_O(mclk_o), .MCLK_OE(mclk_oe), .IRQ_I(pad), .IRQ_O(irq_o), .IRQ_OE(irq_oe),
      .MOD_BIT_I(mod_bit), .POR_PEND_I(por), .CRC_PEND_I(crc), .EOS_PEND_I(eos), .SAMPLE_O(samp),
      .DRDY_O(drdy));
   cdi_host_model host (.drive_val(irq_o), .drive_en(irq_oe), .hold_low(hold), .pad_level(pad));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
      if (k >= 50) fail_count++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // Returns the cycles up to the next sample or data-ready pulse.
   task automatic gap(input logic on_drdy, output int c);
      c = 0;
      do begin @(posedge clk); c++; end while ((on_drdy ? drdy : samp) !== 1'b1 && c < 3000);
   endtask : gap
   task t_reset;
      wb(1'b0, 8'h00, 32'h0);
      `CDI_CHK("clkcfg", 32'h00000002, q)
      wb(1'b0, 8'h04, 32'h0);
      `CDI_CHK("irqcfg", 32'h00000000, q)
      wb(1'b0, 8'h08, 32'h0);
      `CDI_CHK("osr", 32'h00000004, q)
      wb(1'b0, 8'hFC, 32'h0);
      `CDI_CHK("unmapped", 32'h00000000, q)
      `CDI_CHK("mclk oe", 1'b0, mclk_oe)
      $display("test reset done");
   endtask : t_reset
   task t_idle;
      wb(1'b1, 8'h04, 32'h1);
      repeat (2) @(posedge clk);
      `CDI_CHK("idle drive", 2'h3, {irq_oe, irq_o})
      wb(1'b1, 8'h04, 32'h0);
      repeat (2) @(posedge clk);
      `CDI_CHK("idle release", 1'b0, irq_oe)
      eos <= 1'b1;
      repeat (2) @(posedge clk);
      `CDI_CHK("eos low", 2'h2, {irq_oe, pad})
      eos <= 1'b0;
      $display("test idle done");
   endtask : t_idle
   task t_clocks;
      // Three pulses are spanned because a new setting only lands on a sample boundary.
      for (int p = 0; p < 4; p++) begin
         wb(1'b1, 8'h00, 32'h13 | (p << 2));
         repeat (3) gap(1'b0, g);
         `CDI_CHK("sample gap", 8 << p, g)
         `CDI_CHK("mclk out", 1'b1, mclk_oe)
         `CDI_CHK("mclk level", 1'b1, mclk_o)
      end
      wb(1'b1, 8'h00, 32'h10);
      repeat (3) gap(1'b0, g);
      `CDI_CHK("ext gap", 24, g)
      `CDI_CHK("mclk in", 1'b0, mclk_oe)
      $display("test clocks done");
   endtask : t_clocks
   task t_drdy;
      wb(1'b1, 8'h00, 32'h13);
      wb(1'b1, 8'h08, 32'h3);
      wb(1'b1, 8'h14, 32'h1);
      repeat (3) gap(1'b1, g);
      `CDI_CHK("result gap", 24, g)
      for (int i = 1; i <= 6; i++) begin
         @(posedge clk);
         `CDI_CHK("drdy pin", (i >= 5), pad)
      end
      `CDI_CHK("int set", 1'b1, int_o)
      wb(1'b0, 8'h10, 32'h0);
      `CDI_CHK("stat set", 1'b1, q[0])
      wb(1'b0, 8'h10, 32'h0);
      `CDI_CHK("stat clear", 1'b0, q[0])
      `CDI_CHK("int clear", 1'b0, int_o)
      wb(1'b1, 8'h08, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      `CDI_CHK("osr zero", 32'h00000003, q)
      wb(1'b1, 8'h14, 32'h0);
      $display("test drdy done");
   endtask : t_drdy
   task t_modulator_bitstream_out;
      wb(1'b1, 8'h04, 32'h2);
      por <= 1'b1;
      repeat (3) @(posedge clk);
      `CDI_CHK("por low", 2'h2, {irq_oe, pad})
      por <= 1'b0;
      crc <= 1'b1;
      repeat (3) @(posedge clk);
      `CDI_CHK("crc low", 2'h2, {irq_oe, pad})
      crc <= 1'b0;
      mod_bit <= 1'b1;
      repeat (3) gap(1'b0, g);
      `CDI_CHK("modulator_bitstream_out one", 1'b1, pad)
      mod_bit <= 1'b0;
      repeat (3) gap(1'b0, g);
      `CDI_CHK("modulator_bitstream_out zero", 1'b0, pad)
      $display("test modulator_bitstream_out done");
   endtask : t_modulator_bitstream_out
   task t_stuck;
      wb(1'b1, 8'h04, 32'h0);
      hold <= 1'b1;
      repeat (8) @(posedge clk);
      wb(1'b0, 8'h0C, 32'h0);
      `CDI_CHK("state", 3'h3, {q[4], q[1:0]})
      wb(1'b0, 8'h10, 32'h0);
      `CDI_CHK("stuck flag", 1'b1, q[1])
      hold <= 1'b0;
      $display("test stuck done");
   endtask : t_stuck
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_idle();
      t_clocks();
      t_drdy();
      t_modulator_bitstream_out();
      t_stuck();
      tally_and_finish();
   end
endmodule : cdi_clk_irq_bench
